// >>> rtl/rps_flag_hold.sv
// Purpose: Stretches a status event into a flag of minimum length
// Assumes: Event and clear are synchronous to clk
// Notes: Sticky flags fall after the minimum hold once a clear has been seen
`timescale 1ns/100ps
module rps_flag_hold #(
    parameter bit STICKY = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic ser_en,
    input wire logic event_in,
    input wire logic clear,
    // Flag
    output logic flag
);
    import rps_pkg::*;

    logic flag_r;
    logic flag_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic pend_r;
    logic pend_nxt;

    always_comb begin
        flag_nxt = flag_r;
        cnt_nxt = cnt_r;
        pend_nxt = pend_r | clear;
        if (event_in) begin
            // Event wins over a clear in the same cycle
            flag_nxt = 1'b1;
            cnt_nxt = (ser_en ? RPS_HOLD_SER : RPS_HOLD_NO_SER) - 2'h1;
            pend_nxt = 1'b0;
        end else if (cnt_r != 2'h0) begin
            cnt_nxt = cnt_r - 2'h1;
        end else if (!STICKY || pend_r || clear) begin
            flag_nxt = 1'b0;
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_r <= 1'b0;
            cnt_r <= 2'h0;
            pend_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign flag = flag_r;

endmodule // rps_flag_hold

// >>> rtl/rps_pkg.sv
// Purpose: Shared constants and types for the receive status flag block
// Assumes: One recovered parallel clock, synchronous active-high reset
// Notes: Minimum flag hold times are in recovered clock cycles
package rps_pkg;

    // Flag hold times without and with byte serializer
    localparam logic [1:0] RPS_HOLD_NO_SER = 2'h2;
    localparam logic [1:0] RPS_HOLD_SER = 2'h3;

    // Run-length counter width and default threshold
    localparam int RPS_RL_W = 8;
    localparam logic [7:0] RPS_RL_THRESH_DEF = 8'h05;

    // Default rate-match queue depth and reset occupancy
    localparam int RPS_RM_DEPTH_DEF = 16;
    localparam logic [4:0] RPS_RM_OCC_RST = 5'h00;

    // Word aligner modes
    typedef enum logic [1:0] {
        RPS_ALIGN_AUTO = 2'h0,
        RPS_ALIGN_MANUAL = 2'h1,
        RPS_ALIGN_BITSLIP = 2'h2
    } rps_align_mode_t;

    // Lane deskew states, one-hot
    typedef enum logic [7:0] {
        RPS_DSK_LOSS = 8'h01,
        RPS_DSK_DET1 = 8'h02,
        RPS_DSK_DET2 = 8'h04,
        RPS_DSK_DET3 = 8'h08,
        RPS_DSK_ACQ1 = 8'h10,
        RPS_DSK_ACQ2 = 8'h20,
        RPS_DSK_ACQ3 = 8'h40,
        RPS_DSK_ACQ4 = 8'h80
    } rps_dsk_state_t;

endpackage

// >>> rtl/rps_status.sv
// Purpose: Receive path status flags: run length, word sync, deskew, rate match
// Assumes: All inputs synchronous to the recovered parallel clock
// Notes: Configuration inputs are static during operation
`timescale 1ns/100ps

// What this block does
// - Pulse run-length flag when identical consecutive bits exceed the threshold.
// - Run-length pulse lasts two cycles, three with byte serializer.
// - Automatic mode: sync flag high while staying-in-sync conditions hold.
// - Manual mode: sync flag high one cycle on pattern's most significant byte.
// - Bit-slip mode: no sync flag, held low.
// - Sync flag one bit for 8/10 width, two bits for 16/20.
// - Lane deskew aligned flag only active in XAUI mode.
// - Aligned flag high in any ALIGN_ACQUIRED state one to four.
// - Aligned flag low in LOSS_OF_ALIGNMENT or ALIGN_DETECT one to three.
// - Deletion flag high when a rate-match pattern byte is removed.
// - Insertion flag high when a rate-match pattern byte is added.
// - Empty flag raised when a read finds the rate-match queue empty.
// - Full flag raised when a write that is not deleted finds the rate-match queue full.
// - Empty and full stay high at least two cycles, three with serializer.
module rps_status #(
    parameter int DATA_W = 10,
    parameter bit WIDE = 1'b0,
    parameter logic [7:0] RL_THRESH = rps_pkg::RPS_RL_THRESH_DEF,
    parameter int RM_DEPTH = rps_pkg::RPS_RM_DEPTH_DEF,
    parameter int SYNC_W = WIDE ? 2 : 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Static configuration
    input wire logic ser_en,
    input wire rps_pkg::rps_align_mode_t align_mode,
    input wire logic xaui_mode,
    // Received data and word aligner events
    input wire logic [DATA_W-1:0] rx_word,
    input wire logic [SYNC_W-1:0] sync_cond,
    input wire logic [SYNC_W-1:0] pattern_msb,
    // Lane deskew events
    input wire logic align_col,
    input wire logic deskew_err,
    // Rate-match traffic
    input wire logic rm_wr,
    input wire logic rm_wr_pattern,
    input wire logic rm_rd,
    input wire logic rm_rd_pattern,
    input wire logic rx_digital_reset,
    // Status flags
    output logic run_len_viol,
    output logic [SYNC_W-1:0] word_sync,
    output logic lane_aligned,
    output logic rm_deleted,
    output logic rm_inserted,
    output logic rm_empty,
    output logic rm_full
);
    import rps_pkg::*;

    localparam int OCC_W = $clog2(RM_DEPTH + 1);
    localparam logic [OCC_W-1:0] OCC_MAX = OCC_W'(RM_DEPTH);
    localparam logic [OCC_W-1:0] OCC_HI = OCC_W'((RM_DEPTH * 3) / 4);
    localparam logic [OCC_W-1:0] OCC_LO = OCC_W'(RM_DEPTH / 4);

    // Scan one word LSB first; returns {violation, last bit, run count}
    function automatic logic [RPS_RL_W+1:0] rl_scan(
        input logic [DATA_W-1:0] word,
        input logic last_bit,
        input logic [RPS_RL_W-1:0] run
    );
        logic viol;
        logic lb;
        logic [RPS_RL_W-1:0] cnt;
        viol = 1'b0;
        lb = last_bit;
        cnt = run;
        for (int i = 0; i < DATA_W; i++) begin
            if (word[i] == lb) begin
                if (cnt != {RPS_RL_W{1'b1}}) begin
                    cnt = cnt + 1'b1;
                end
            end else begin
                cnt = RPS_RL_W'(1);
            end
            lb = word[i];
            if (cnt > RL_THRESH) begin
                viol = 1'b1;
            end
        end
        return {viol, lb, cnt};
    endfunction

    // Run-length state
    logic last_bit_r;
    logic last_bit_nxt;
    logic [RPS_RL_W-1:0] run_r;
    logic [RPS_RL_W-1:0] run_nxt;
    logic rl_event;

    always_comb begin
        logic [RPS_RL_W+1:0] scan;
        scan = rl_scan(rx_word, last_bit_r, run_r);
        rl_event = scan[RPS_RL_W+1];
        last_bit_nxt = scan[RPS_RL_W];
        run_nxt = scan[RPS_RL_W-1:0];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_bit_r <= 1'b0;
            run_r <= '0;
        end else begin
            last_bit_r <= last_bit_nxt;
            run_r <= run_nxt;
        end
    end

    rps_flag_hold #(
        .STICKY(1'b0)
    ) u_rlv_hold (
        .clk(clk),
        .sys_rst(sys_rst),
        .ser_en(ser_en),
        .event_in(rl_event),
        .clear(1'b0),
        .flag(run_len_viol)
    );

    // Word sync flag
    logic [SYNC_W-1:0] sync_r;
    logic [SYNC_W-1:0] sync_nxt;

    always_comb begin
        case (align_mode)
            RPS_ALIGN_AUTO: sync_nxt = sync_cond;
            RPS_ALIGN_MANUAL: sync_nxt = pattern_msb & ~sync_r;
            default: sync_nxt = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign word_sync = sync_r;

    // Lane deskew state machine
    rps_dsk_state_t dsk_r;
    rps_dsk_state_t dsk_nxt;
    logic aligned_r;
    logic aligned_nxt;

    always_comb begin
        dsk_nxt = dsk_r;
        case (dsk_r)
            RPS_DSK_LOSS: begin
                if (align_col) dsk_nxt = RPS_DSK_DET1;
            end
            RPS_DSK_DET1: begin
                if (deskew_err) dsk_nxt = RPS_DSK_LOSS;
                else if (align_col) dsk_nxt = RPS_DSK_DET2;
            end
            RPS_DSK_DET2: begin
                if (deskew_err) dsk_nxt = RPS_DSK_LOSS;
                else if (align_col) dsk_nxt = RPS_DSK_DET3;
            end
            RPS_DSK_DET3: begin
                if (deskew_err) dsk_nxt = RPS_DSK_LOSS;
                else if (align_col) dsk_nxt = RPS_DSK_ACQ1;
            end
            RPS_DSK_ACQ1: begin
                if (deskew_err) dsk_nxt = RPS_DSK_ACQ2;
            end
            RPS_DSK_ACQ2: begin
                if (deskew_err) dsk_nxt = RPS_DSK_ACQ3;
                else if (align_col) dsk_nxt = RPS_DSK_ACQ1;
            end
            RPS_DSK_ACQ3: begin
                if (deskew_err) dsk_nxt = RPS_DSK_ACQ4;
                else if (align_col) dsk_nxt = RPS_DSK_ACQ2;
            end
            RPS_DSK_ACQ4: begin
                if (deskew_err) dsk_nxt = RPS_DSK_LOSS;
                else if (align_col) dsk_nxt = RPS_DSK_ACQ3;
            end
            default: dsk_nxt = RPS_DSK_LOSS;
        endcase
        if (!xaui_mode) begin
            dsk_nxt = RPS_DSK_LOSS;
        end
        aligned_nxt = xaui_mode && (dsk_nxt == RPS_DSK_ACQ1 || dsk_nxt == RPS_DSK_ACQ2
            || dsk_nxt == RPS_DSK_ACQ3 || dsk_nxt == RPS_DSK_ACQ4);
        // Loss and detect states leave the flag low
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dsk_r <= RPS_DSK_LOSS;
            aligned_r <= 1'b0;
        end else begin
            dsk_r <= dsk_nxt;
            aligned_r <= aligned_nxt;
        end
    end

    assign lane_aligned = aligned_r;

    // Rate-match occupancy and events
    logic [OCC_W-1:0] occ_r;
    logic [OCC_W-1:0] occ_nxt;
    logic del_r;
    logic del_nxt;
    logic ins_r;
    logic ins_nxt;
    logic empty_ev;
    logic full_ev;

    always_comb begin
        logic do_wr;
        logic do_rd;
        do_wr = 1'b0;
        do_rd = 1'b0;
        del_nxt = 1'b0;
        ins_nxt = 1'b0;
        empty_ev = 1'b0;
        full_ev = 1'b0;
        if (rm_wr) begin
            if (rm_wr_pattern && occ_r >= OCC_HI) begin
                del_nxt = 1'b1;
            end else if (occ_r == OCC_MAX) begin
                full_ev = 1'b1;
            end else begin
                do_wr = 1'b1;
            end
        end
        if (rm_rd) begin
            if (occ_r == '0) begin
                empty_ev = 1'b1;
            end else if (rm_rd_pattern && occ_r <= OCC_LO) begin
                ins_nxt = 1'b1;
            end else begin
                do_rd = 1'b1;
            end
        end
        occ_nxt = occ_r;
        if (do_wr && !do_rd) begin
            occ_nxt = occ_r + 1'b1;
        end else if (do_rd && !do_wr) begin
            occ_nxt = occ_r - 1'b1;
        end
        if (rx_digital_reset) begin
            occ_nxt = RPS_RM_OCC_RST[OCC_W-1:0];
            del_nxt = 1'b0;
            ins_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            occ_r <= RPS_RM_OCC_RST[OCC_W-1:0];
            del_r <= 1'b0;
            ins_r <= 1'b0;
        end else begin
            occ_r <= occ_nxt;
            del_r <= del_nxt;
            ins_r <= ins_nxt;
        end
    end

    assign rm_deleted = del_r;
    assign rm_inserted = ins_r;

    rps_flag_hold #(
        .STICKY(1'b1)
    ) u_empty_hold (
        .clk(clk),
        .sys_rst(sys_rst),
        .ser_en(ser_en),
        .event_in(empty_ev),
        .clear(rx_digital_reset),
        .flag(rm_empty)
    );

    rps_flag_hold #(
        .STICKY(1'b1)
    ) u_full_hold (
        .clk(clk),
        .sys_rst(sys_rst),
        .ser_en(ser_en),
        .event_in(full_ev),
        .clear(rx_digital_reset),
        .flag(rm_full)
    );

endmodule // rps_status

// >>> tb/rps_fabric.sv
// Purpose: Fabric model clearing rate-match flags by digital reset
// Assumes: Flags synchronous to clk
// Notes: lag sets how long the clear waits
`timescale 1ns/100ps
module rps_fabric (
    // Clock and reset
    input logic clk,
    input logic sys_rst,
    // Watched flags
    input logic rm_empty,
    input logic rm_full,
    input logic [7:0] lag,
    // Clear
    output logic rx_digital_reset = 1'h0
);
    logic [7:0] wait_r = 8'h00;
    always @(posedge clk) begin
        rx_digital_reset <= 1'h0;
        if (sys_rst || !(rm_empty || rm_full)) begin
            wait_r <= 8'h00;
        end else begin
            wait_r <= wait_r + 8'h01;
            rx_digital_reset <= (wait_r == lag);
        end
    end
endmodule // rps_fabric

// >>> tb/rps_status_asserts.sv
// Purpose: Concurrent checks on the receive status flags
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into every status block
`timescale 1ns/100ps
module rps_status_chk #(
    parameter int SYNC_W = 1
) (
    // Clock and reset
    input logic clk,
    input logic sys_rst,
    // Configuration
    input logic ser_en,
    input rps_pkg::rps_align_mode_t align_mode,
    input logic xaui_mode,
    // Events
    input logic [SYNC_W-1:0] sync_cond,
    input logic [SYNC_W-1:0] pattern_msb,
    input logic align_col,
    input logic deskew_err,
    input logic rm_wr,
    input logic rm_wr_pattern,
    input logic rm_rd,
    input logic rm_rd_pattern,
    // Flags
    input logic run_len_viol,
    input logic [SYNC_W-1:0] word_sync,
    input logic lane_aligned,
    input logic rm_deleted,
    input logic rm_inserted,
    input logic rm_empty,
    input logic rm_full
);
    import rps_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_held(f);
        ##1 f ##1 (f || !ser_en);
    endsequence
    sequence s_msb_up;
        align_mode == RPS_ALIGN_MANUAL && !$past(sys_rst) && $rose(pattern_msb[0]);
    endsequence
    sequence s_cols;
        (xaui_mode && align_col && !deskew_err) [*4];
    endsequence
    chk_rlv_hold: assert property ($rose(run_len_viol) |-> s_held(run_len_viol))
        else $error("run length flag short");
    chk_empty_hold: assert property ($rose(rm_empty) |-> s_held(rm_empty))
        else $error("empty flag short");
    chk_full_hold: assert property ($rose(rm_full) |-> s_held(rm_full))
        else $error("full flag short");
    chk_bitslip_sync: assert property (align_mode == RPS_ALIGN_BITSLIP |-> word_sync == '0)
        else $error("sync flag in bit-slip");
    chk_auto_sync: assert property (align_mode == RPS_ALIGN_AUTO |=> word_sync == $past(sync_cond))
        else $error("auto sync mismatch");
    chk_manual_pulse: assert property (s_msb_up |=> word_sync[0] ##1 !word_sync[0])
        else $error("manual sync pulse");
    chk_dsk_acquire: assert property (s_cols |=> lane_aligned)
        else $error("not aligned after columns");
    chk_del_cause: assert property (rm_deleted |-> $past(rm_wr && rm_wr_pattern))
        else $error("deletion without cause");
    chk_ins_cause: assert property (rm_inserted |-> $past(rm_rd && rm_rd_pattern))
        else $error("insertion without cause");
    chk_empty_cause: assert property ($rose(rm_empty) |-> $past(rm_rd))
        else $error("empty without read");
endmodule // rps_status_chk

bind rps_status rps_status_chk #(.SYNC_W(SYNC_W)) u_chk (.clk, .sys_rst, .ser_en, .align_mode,
    .xaui_mode, .sync_cond, .pattern_msb, .align_col, .deskew_err, .rm_wr, .rm_wr_pattern,
    .rm_rd, .rm_rd_pattern, .run_len_viol, .word_sync, .lane_aligned, .rm_deleted,
    .rm_inserted, .rm_empty, .rm_full);

// >>> tb/test_rps_status.sv
// Purpose: Self-checking bench for the receive status flags
// Assumes: Fabric model clears rate-match flags
// Notes: Configuration changes only under reset
`timescale 1ns/100ps
module test_rps_status;
    import rps_pkg::*;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic ser_en = 1'h0;
    rps_align_mode_t align_mode = RPS_ALIGN_AUTO;
    logic xaui_mode = 1'h0;
    logic [9:0] rx_word = 10'h155;
    logic [0:0] sync_cond = 1'h0;
    logic [0:0] pattern_msb = 1'h0;
    logic align_col = 1'h0;
    logic deskew_err = 1'h0;
    logic rm_wr = 1'h0;
    logic rm_wr_pattern = 1'h0;
    logic rm_rd = 1'h0;
    logic rm_rd_pattern = 1'h0;
    logic [7:0] lag = 8'h00;
    logic rx_digital_reset, run_len_viol, lane_aligned, rm_deleted, rm_inserted;
    logic rm_empty, rm_full;
    logic [0:0] word_sync;
    int err_count = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    rps_status #(.DATA_W(10), .WIDE(1'h0), .RL_THRESH(8'h05), .RM_DEPTH(16)) DUT (.clk,
        .sys_rst, .ser_en, .align_mode, .xaui_mode, .rx_word, .sync_cond, .pattern_msb,
        .align_col, .deskew_err, .rm_wr, .rm_wr_pattern, .rm_rd, .rm_rd_pattern,
        .rx_digital_reset, .run_len_viol, .word_sync, .lane_aligned, .rm_deleted,
        .rm_inserted, .rm_empty, .rm_full);
    rps_fabric FAB (.clk, .sys_rst, .rm_empty, .rm_full, .lag, .rx_digital_reset);
    task chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'h1) begin
            err_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task setup(input logic s, input rps_align_mode_t m, input logic x);
        @(posedge clk);
        sys_rst <= 1'h1;
        ser_en <= s;
        align_mode <= m;
        xaui_mode <= x;
        lag <= s ? 8'h04 : 8'h00;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
    endtask
    task cyc(input logic [3:0] v);
        @(posedge clk);
        {rm_wr, rm_wr_pattern, rm_rd, rm_rd_pattern} <= v;
    endtask
    task t_rlv(input logic s);
        logic [9:0] w [8];
        int n;
        w = '{10'h155, 10'h01f, 10'h155, 10'h3f0, 10'h2aa, 10'h2aa, 10'h2aa, 10'h2aa};
        n = 0;
        setup(s, RPS_ALIGN_AUTO, 1'h0);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            rx_word <= w[i];
            #1 n += int'(run_len_viol === 1'h1);
        end
        chk(n == (s ? 3 : 2), "run length pulse");
        $display("run length test done");
    endtask
    task t_sync(input rps_align_mode_t m, input int e);
        int n;
        n = 0;
        setup(1'h0, m, 1'h0);
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            sync_cond <= (i > 0 && i < 4);
            pattern_msb <= (i == 1 || i == 2);
            #1 n += int'(word_sync === 1'h1);
        end
        chk(n == e, "sync flag count");
        $display("sync test done");
    endtask
    task t_dsk(input logic x);
        setup(1'h0, RPS_ALIGN_AUTO, x);
        @(posedge clk);
        align_col <= 1'h1;
        repeat (3) @(posedge clk);
        #1 chk(lane_aligned === 1'h0, "aligned too early");
        @(posedge clk);
        align_col <= 1'h0;
        #1 chk(lane_aligned === x, "aligned after columns");
        @(posedge clk);
        deskew_err <= 1'h1;
        repeat (3) @(posedge clk);
        #1 chk(lane_aligned === x, "aligned through errors");
        @(posedge clk);
        deskew_err <= 1'h0;
        #1 chk(lane_aligned === 1'h0, "loss after errors");
        $display("deskew test done");
    endtask
    task hold(input logic f);
        int n;
        n = 0;
        for (int i = 0; i < 14; i++) begin
            cyc(4'h0);
            #1 n += int'((f ? rm_full : rm_empty) === 1'h1);
        end
        chk(n >= (ser_en ? 3 : 2), "flag hold");
        chk((f ? rm_full : rm_empty) === 1'h0, "flag not cleared");
    endtask
    task t_rm(input logic s);
        setup(s, RPS_ALIGN_AUTO, 1'h0);
        repeat (12) cyc(4'h8);
        cyc(4'hc);
        cyc(4'h8);
        #1 chk(rm_deleted === 1'h1, "deletion");
        repeat (4) cyc(4'h8);
        hold(1'h1);
        repeat (2) cyc(4'h8);
        cyc(4'h3);
        cyc(4'h2);
        #1 chk(rm_inserted === 1'h1, "insertion");
        repeat (2) cyc(4'h2);
        hold(1'h0);
        $display("rate match test done");
    endtask
    initial begin
        #2000000;
        err_count++;
        wrap_up;
    end
    initial begin
        for (int s = 0; s < 2; s++) begin
            t_rlv(1'(s));
            t_rm(1'(s));
        end
        t_sync(RPS_ALIGN_AUTO, 3);
        t_sync(RPS_ALIGN_MANUAL, 1);
        t_sync(RPS_ALIGN_BITSLIP, 0);
        t_dsk(1'h1);
        t_dsk(1'h0);
        wrap_up;
    end
endmodule // test_rps_status
